// file: hdl/dbs_pkg.sv
// Package: constants and carrier types for the burst-of-four SRAM port
package dbs_pkg;
   localparam int DBS_AW = 8;
   localparam int DBS_LANES = 4;
   localparam int DBS_LANE_W = 9;
   localparam int DBS_DW = DBS_LANES * DBS_LANE_W;
   localparam int DBS_BEATS = 4;
   localparam int DBS_FIFO_DEPTH = 8;
   // Impedance evaluation interval in cycles and code width
   localparam int DBS_ZQ_PERIOD = 64;
   localparam int DBS_ZQ_CW = 6;
   localparam logic [5:0] DBS_ZQ_RST = 6'h20;
   localparam logic [5:0] DBS_ZQ_MINIMP = 6'h3F;
   localparam logic [6:0] DBS_ZQ_LAST = 7'h3F;
   // Read beat pipeline depth in half cycles (first beat at n+2.5)
   localparam int DBS_RD_LAT = 5;

   typedef struct packed {
      logic [DBS_AW-1:0] addr;
      logic [DBS_DW-1:0] data;
      logic [DBS_LANES-1:0] mask_n;
   } dbs_beat_t;

   typedef struct packed {
      logic [DBS_AW-1:0] addr;
      logic [DBS_BEATS*DBS_DW-1:0] data;
      logic [DBS_BEATS*DBS_LANES-1:0] mask_n;
   } dbs_wr_t;

   typedef enum logic [1:0] {
      DBS_IDLE = 2'b00,
      DBS_READ = 2'b01,
      DBS_WRITE = 2'b10
   } dbs_cmd_t;
endpackage

// file: hdl/dbs_fifo.sv
// Module: parameterised valid/ready FIFO for assembled write bursts
`timescale 1ns/1ps
module dbs_fifo import dbs_pkg::*; #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0] wr_q;
   logic [PW:0] rd_q;
   logic push;
   logic pop;

   // Full and empty from pointer compare
   assign in_ready = (wr_q - rd_q) != (PW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_q[PW-1:0]];

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[PW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   fifo_no_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
      (PW+1)'(wr_q - rd_q) <= (PW+1)'(DEPTH)) else $error("fifo occupancy above depth");
endmodule

// file: hdl/dbs_port.sv
// Module: DDR burst-of-four separate I/O SRAM port, device side
`timescale 1ns/1ps
// Operation
// - Address and commands captured on clock rise
// - Both commands high means deselect
// - Low read command starts a read
// - Read ignored right after a read
// - High read command deselects read port
// - Write low, read high starts write
// - Write ignored right after a write
// - Four write beats captured in order
// - Masks sampled with each data beat
// - High mask keeps the stored byte
// - Nine-bit lanes, each masked alone
// - One address per four-beat array write
// - Driver impedance tracks one fifth reference
// - Free counter triggers periodic evaluation
// - At most one step per evaluation
// - Binary-weighted code, one step per LSB
// - Low PLL disable input stops PLL
// - Termination range select chooses range
// - Reference tied to supply gives minimum
// - Read beats from n+2.5 to n+4
// - Mask lane k covers bits 9k..9k+8
//
// The double-rate link is modelled on a half-cycle clock: clk runs at twice the
// input clock rate and k_phase marks the rising positive-clock half (phase 1).
module dbs_port import dbs_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic k_phase,
   input wire logic [DBS_AW-1:0] sync_addr_in,
   input wire logic rd_cmd_n,
   input wire logic wr_cmd_n,
   input wire logic [DBS_DW-1:0] wr_data_in,
   input wire logic [DBS_LANES-1:0] byte_mask_n,
   input wire logic pll_off_n,
   input wire logic term_range_sel,
   input wire logic imp_ref_tied,
   input wire logic imp_cmp_high,
   output logic [DBS_DW-1:0] rd_data_out,
   output logic read_valid_out,
   output logic echo_clk_out,
   output logic echo_clk_out_n,
   output logic pll_enable,
   output logic term_low_range,
   output logic [DBS_ZQ_CW-1:0] drive_code,
   output logic wr_busy
);
   localparam logic [2:0] LAST_BEAT = 3'(DBS_BEATS - 1);
   localparam logic [6:0] ZQ_END = 7'(DBS_ZQ_PERIOD - 1);

   logic [DBS_DW-1:0] mem [2**DBS_AW];

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers for asynchronous straps and pins
   logic [1:0] off_s_q;
   logic [1:0] odt_s_q;
   logic [1:0] tie_s_q;
   logic [1:0] cmp_s_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         off_s_q <= 2'h0;
         odt_s_q <= 2'h3;
         tie_s_q <= 2'h0;
         cmp_s_q <= 2'h0;
      end else begin
         off_s_q <= {off_s_q[0], pll_off_n};
         odt_s_q <= {odt_s_q[0], term_range_sel};
         tie_s_q <= {tie_s_q[0], imp_ref_tied};
         cmp_s_q <= {cmp_s_q[0], imp_cmp_high};
      end
   end

   // Mode outputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pll_enable <= 1'b0;
         term_low_range <= 1'b0;
      end else begin
         pll_enable <= off_s_q[1];
         term_low_range <= !odt_s_q[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode
   dbs_cmd_t last_q;
   logic rd_go;
   logic wr_go;
   // Read wins; previous-command lockout blocks back to back
   assign rd_go = k_phase && !rd_cmd_n && (last_q != DBS_READ);
   assign wr_go = k_phase && !wr_cmd_n && (rd_cmd_n || last_q == DBS_READ)
                  && (last_q != DBS_WRITE) && !rd_go;

   // Remember last loaded command
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         last_q <= DBS_IDLE;
      end else if (k_phase) begin
         unique case (1'b1)
            rd_go: last_q <= DBS_READ;
            wr_go: last_q <= DBS_WRITE;
            default: last_q <= DBS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write beat capture: starts two half cycles after command
   logic [2:0] wcnt_q;
   logic wact_q;
   logic wpend_q;
   logic [DBS_AW-1:0] waddr_q;
   dbs_wr_t wacc_q;
   logic wpush_q;
   logic fifo_in_ready;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wpend_q <= 1'b0;
         wact_q <= 1'b0;
         wcnt_q <= 3'h0;
         waddr_q <= '0;
      end else begin
         // Beat count first, so a burst queued behind it restarts it
         if (wact_q) begin
            wcnt_q <= wcnt_q + 3'h1;
            if (wcnt_q == LAST_BEAT) begin
               wact_q <= 1'b0;
            end
         end
         if (wr_go) begin
            wpend_q <= 1'b1;
            waddr_q <= sync_addr_in;
         end else if (wpend_q) begin
            wpend_q <= 1'b0; // First beat on the next positive rise
            wact_q <= 1'b1;
            wcnt_q <= 3'h0;
         end
      end
   end

   // Data and masks taken together per beat
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wacc_q <= '0;
         wpush_q <= 1'b0;
      end else begin
         wpush_q <= wact_q && wcnt_q == LAST_BEAT;
         if (wact_q) begin
            wacc_q.data[wcnt_q[1:0]*DBS_DW +: DBS_DW] <= wr_data_in;
            wacc_q.mask_n[wcnt_q[1:0]*DBS_LANES +: DBS_LANES] <= byte_mask_n;
            if (wcnt_q == 3'h0) begin
               wacc_q.addr <= waddr_q; // Fixed at first beat, next write may load
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burst FIFO between capture and array
   dbs_wr_t fifo_out;
   logic fifo_out_valid;
   logic [1:0] beat_q;
   logic drain;
   assign wr_busy = !fifo_in_ready;
   dbs_fifo #(.WIDTH($bits(dbs_wr_t)), .DEPTH(DBS_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(wpush_q),
      .in_ready(fifo_in_ready),
      .in_data(wacc_q),
      .out_valid(fifo_out_valid),
      .out_ready(drain),
      .out_data(fifo_out)
   );

   // One word per beat written; burst retires after four
   assign drain = fifo_out_valid && beat_q == 2'h3;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         beat_q <= 2'h0;
      end else if (fifo_out_valid) begin
         beat_q <= beat_q + 2'h1;
      end
   end

   // Masked array write, lane k is bits 9k..9k+8
   logic [DBS_AW-1:0] warr_addr;
   assign warr_addr = {fifo_out.addr[DBS_AW-1:2], beat_q};
   always_ff @(posedge clk) begin
      for (int k = 0; k < DBS_LANES; k++) begin
         if (fifo_out_valid && !fifo_out.mask_n[beat_q*DBS_LANES + k]) begin
            mem[warr_addr][k*DBS_LANE_W +: DBS_LANE_W] <=
               fifo_out.data[beat_q*DBS_DW + k*DBS_LANE_W +: DBS_LANE_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read pipeline: delay then four beats
   // Output register supplies the last half cycle of latency
   logic [DBS_RD_LAT-2:0] rdly_q;
   logic [DBS_AW-1:0] raddr_q;
   logic [2:0] rcnt_q;
   logic ract_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdly_q <= '0;
         raddr_q <= '0;
         ract_q <= 1'b0;
         rcnt_q <= 3'h0;
      end else begin
         rdly_q <= {rdly_q[DBS_RD_LAT-3:0], rd_go};
         if (rd_go) begin
            raddr_q <= sync_addr_in;
         end
         if (rdly_q[DBS_RD_LAT-2]) begin
            ract_q <= 1'b1;
            rcnt_q <= 3'h0;
         end else if (ract_q) begin
            rcnt_q <= rcnt_q + 3'h1;
            if (rcnt_q == LAST_BEAT) begin
               ract_q <= 1'b0;
            end
         end
      end
   end

   // Output data, valid and echo clocks
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data_out <= '0;
         read_valid_out <= 1'b0;
         echo_clk_out <= 1'b0;
         echo_clk_out_n <= 1'b1;
      end else begin
         read_valid_out <= ract_q;
         if (ract_q) begin
            rd_data_out <= mem[{raddr_q[DBS_AW-1:2], rcnt_q[1:0]}];
         end
         echo_clk_out <= ract_q && !rcnt_q[0];
         echo_clk_out_n <= !(ract_q && !rcnt_q[0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Impedance calibration counter and stepping
   logic [6:0] zcnt_q;
   logic zeval;
   assign zeval = zcnt_q == ZQ_END;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         zcnt_q <= 7'h00;
      end else begin
         zcnt_q <= zeval ? 7'h00 : zcnt_q + 7'h01;
      end
   end

   // Step code one LSB toward comparator target
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drive_code <= DBS_ZQ_RST;
      end else if (tie_s_q[1]) begin
         drive_code <= DBS_ZQ_MINIMP;
      end else if (zeval) begin
         if (cmp_s_q[1] && drive_code != DBS_ZQ_LAST[5:0]) begin
            drive_code <= drive_code + 6'h01;
         end else if (!cmp_s_q[1] && drive_code != 6'h00) begin
            drive_code <= drive_code - 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command acceptance checks
   odd_edge_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !k_phase |-> !rd_go && !wr_go) else $error("command taken off positive rise");
   deselect_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (rd_cmd_n && wr_cmd_n) |-> !rd_go && !wr_go) else $error("deselect started op");
   read_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      k_phase && !rd_cmd_n && last_q != DBS_READ |-> rd_go) else $error("read not taken");
   no_back_reads_a: assert property (@(posedge clk) disable iff (!rst_n)
      rd_go |-> ##2 !rd_go) else $error("read taken back to back");
   read_desel_a: assert property (@(posedge clk) disable iff (!rst_n)
      k_phase && rd_cmd_n |-> !rd_go) else $error("read taken while deselected");
   write_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      k_phase && !wr_cmd_n && rd_cmd_n && last_q != DBS_WRITE |-> wr_go)
      else $error("write not taken");
   no_back_writes_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_go |-> ##2 !wr_go) else $error("write taken back to back");

   // Write path checks
   write_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_go |=> waddr_q == $past(sync_addr_in)) else $error("write address not held");
   write_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
      wpend_q && !wr_go |=> wact_q && wcnt_q == 3'h0) else $error("beat capture not armed");
   write_burst_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_go |-> ##2 wact_q [*4] ##1 wpush_q) else $error("write beats wrong");
   write_push_a: assert property (@(posedge clk) disable iff (!rst_n)
      wpush_q |-> fifo_in_ready) else $error("burst pushed into full fifo");

   // Read path checks
   read_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
      rd_go |=> raddr_q == $past(sync_addr_in)) else $error("read address not held");
   read_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
      rd_go |-> ##6 read_valid_out [*4])
      else $error("read beats late");
   read_end_a: assert property (@(posedge clk) disable iff (!rst_n)
      ract_q && rcnt_q == LAST_BEAT && !rdly_q[DBS_RD_LAT-2] |=> !ract_q)
      else $error("read burst too long");
   echo_beats_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(read_valid_out) |-> echo_clk_out ##1 (read_valid_out && !echo_clk_out))
      else $error("echo clock not in step with beats");
   echo_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !read_valid_out |-> !echo_clk_out && echo_clk_out_n) else $error("echo clock off idle");

   // Impedance checks
   zq_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      !tie_s_q[1] && !$past(tie_s_q[1]) && $past(!zeval) |-> $stable(drive_code))
      else $error("code moved off evaluation");
   zq_one_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      zeval && !tie_s_q[1] |=> (drive_code == $past(drive_code)
         || drive_code == $past(drive_code) + 6'h01
         || drive_code == $past(drive_code) - 6'h01))
      else $error("code moved more than one step");
   zq_min_a: assert property (@(posedge clk) disable iff (!rst_n)
      tie_s_q[1] |=> drive_code == DBS_ZQ_MINIMP) else $error("tied ref not minimum");
   zq_period_a: assert property (@(posedge clk) disable iff (!rst_n)
      zeval |=> !zeval [*8]) else $error("evaluation too often");

   // Mode pin checks
   pll_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      off_s_q[1] |=> pll_enable) else $error("pll enable wrong");
   pll_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      !off_s_q[1] |=> !pll_enable) else $error("pll not disabled");
   term_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      odt_s_q[1] |=> !term_low_range) else $error("high range not chosen");
   term_on_a: assert property (@(posedge clk) disable iff (!rst_n)
      !odt_s_q[1] |=> term_low_range) else $error("low range not chosen");

   // Scenario covers
   read_seen_c: cover property (@(posedge clk) disable iff (!rst_n) rd_go);
   write_seen_c: cover property (@(posedge clk) disable iff (!rst_n) wpush_q);
   rw_alt_c: cover property (@(posedge clk) disable iff (!rst_n) rd_go ##2 wr_go);
   back_writes_c: cover property (@(posedge clk) disable iff (!rst_n) wr_go ##4 wr_go);
   fifo_full_c: cover property (@(posedge clk) disable iff (!rst_n) wr_busy);
endmodule

// file: verif/dbs_ctl.sv
// Controller model: drives commands and write beats into the port
`timescale 1ns/1ps
module dbs_ctl import dbs_pkg::*; (
   input wire logic clk,
   output logic k_phase,
   output logic [DBS_AW-1:0] addr,
   output logic rd_n,
   output logic wr_n,
   output logic [DBS_DW-1:0] data,
   output logic [DBS_LANES-1:0] mask_n
);
   // Idle levels, both commands high
   initial begin
      k_phase = 1'b0;
      addr = '0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      data = '0;
      mask_n = '1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Marks every other edge as a positive rise
   always @(negedge clk) begin
      k_phase <= ~k_phase;
   end
   // One command on a positive rise, then idle
   task automatic send_cmd(input logic r, input logic w, input logic [DBS_AW-1:0] a);
      @(negedge clk);
      #1;
      if (!k_phase) begin
         @(negedge clk);
         #1;
      end
      rd_n = r;
      wr_n = w;
      addr = a;
      @(negedge clk);
      #1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = ~a;
   endtask
   // Four beats with their masks, then inverted lines
   task automatic send_beats(input dbs_wr_t b);
      for (int i = 0; i < DBS_BEATS; i++) begin
         @(negedge clk);
         #1;
         data = b.data[i*DBS_DW +: DBS_DW];
         mask_n = b.mask_n[i*DBS_LANES +: DBS_LANES];
      end
      @(negedge clk);
      #1;
      data = ~data;
      mask_n = ~mask_n;
   endtask
endmodule

// file: verif/tb.sv
// Testbench for the burst-of-four SRAM port
`timescale 1ns/1ps
module tb import dbs_pkg::*; ();
   logic clk, rst_n, k_phase, rd_n, wr_n, pll_off_n, term_range_sel, imp_ref_tied;
   logic imp_cmp_high, read_valid_out, echo_clk_out, echo_clk_out_n;
   logic pll_enable, term_low_range, wr_busy;
   logic [DBS_AW-1:0] addr;
   logic [DBS_DW-1:0] data, rd_data_out;
   logic [DBS_LANES-1:0] mask_n;
   logic [DBS_ZQ_CW-1:0] drive_code;
   logic [DBS_DW-1:0] mem [2**DBS_AW];
   int n_errors = 0;
   int total_checks = 0;

   dbs_ctl ctl (.clk(clk), .k_phase(k_phase), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
      .data(data), .mask_n(mask_n));
   dbs_port uut (.clk(clk), .rst_n(rst_n), .k_phase(k_phase), .sync_addr_in(addr),
      .rd_cmd_n(rd_n), .wr_cmd_n(wr_n), .wr_data_in(data), .byte_mask_n(mask_n),
      .pll_off_n(pll_off_n), .term_range_sel(term_range_sel), .imp_ref_tied(imp_ref_tied),
      .imp_cmp_high(imp_cmp_high), .rd_data_out(rd_data_out),
      .read_valid_out(read_valid_out), .echo_clk_out(echo_clk_out),
      .echo_clk_out_n(echo_clk_out_n), .pll_enable(pll_enable),
      .term_low_range(term_low_range), .drive_code(drive_code), .wr_busy(wr_busy));

   always #25 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   // Compare, count, report
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Burst with counting beat data
   function automatic dbs_wr_t mk(input logic [7:0] a, input logic [35:0] s,
      input logic [15:0] m);
      return '{a, {s + 36'h3, s + 36'h2, s + 36'h1, s}, m};
   endfunction
   // Shadow array update, masked lanes kept
   task automatic upd(input dbs_wr_t w);
      for (int i = 0; i < DBS_BEATS; i++) begin
         for (int k = 0; k < DBS_LANES; k++) begin
            if (!w.mask_n[i*DBS_LANES+k]) begin
               mem[{w.addr[7:2], 2'(i)}][k*DBS_LANE_W +: DBS_LANE_W] =
                  w.data[i*DBS_DW+k*DBS_LANE_W +: DBS_LANE_W];
            end
         end
      end
   endtask
   // Whole write burst
   task automatic wr(input dbs_wr_t w);
      ctl.send_cmd(1'b1, 1'b0, w.addr);
      ctl.send_beats(w);
      upd(w);
   endtask
   // Read burst, beats and echo judged cycle by cycle
   task automatic rd_chk(input logic [7:0] a);
      ctl.send_cmd(1'b0, 1'b1, a);
      repeat (4) @(negedge clk);
      check("valid_early", read_valid_out, 0);
      for (int i = 0; i < DBS_BEATS; i++) begin
         @(negedge clk);
         check("valid", read_valid_out, 1);
         check("rdata", rd_data_out, mem[{a[7:2], 2'(i)}]);
         check("echo", echo_clk_out, !i[0]);
         check("echo_n", echo_clk_out_n, i[0]);
      end
      @(negedge clk);
      check("valid_late", read_valid_out, 0);
      check("busy", wr_busy, 0);
   endtask
   // Count read beats over a window
   task automatic cnt_valid(inout int n);
      repeat (14) begin
         @(negedge clk);
         n += read_valid_out;
      end
   endtask
   // Impedance walk in one direction
   task automatic zq_walk(input logic up, input int len, input int lo, input int hi);
      logic [DBS_ZQ_CW-1:0] c;
      int gap;
      int steps;
      imp_cmp_high = up;
      repeat (4) @(negedge clk);
      c = drive_code;
      gap = 0;
      steps = 0;
      repeat (len) begin
         @(negedge clk);
         gap++;
         if (drive_code !== c) begin
            check("zq_step", drive_code, up ? c + 6'h01 : c - 6'h01);
            if (steps > 0) check("zq_gap", gap, DBS_ZQ_PERIOD);
            steps++;
            gap = 0;
            c = drive_code;
         end
      end
      check("zq_count", steps >= lo && steps <= hi, 1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Plain and masked bursts
   task automatic t_basic;
      wr(mk(8'h40, 36'h1_2345_6789, 16'h0000));
      wr(mk(8'h10, 36'hA_BCDE_F012, 16'h0000));
      rd_chk(8'h40);
      rd_chk(8'h13);
      wr(mk(8'h10, 36'h5_5AA5_5AA5, 16'h7BDE));
      wr(mk(8'h10, 36'h0_0FF0_0FF0, 16'h8421));
      rd_chk(8'h10);
      $display("t_basic done");
   endtask
   // Back-to-back and colliding commands
   task automatic t_b2b;
      dbs_wr_t w;
      int n;
      w = mk(8'h20, 36'hC_3C3C_3C3C, 16'h0000);
      ctl.send_cmd(1'b1, 1'b0, w.addr);
      fork
         ctl.send_beats(w);
         ctl.send_cmd(1'b1, 1'b0, 8'h40);
      join
      upd(w);
      rd_chk(8'h40);
      rd_chk(8'h20);
      n = 0;
      ctl.send_cmd(1'b0, 1'b1, 8'h40);
      ctl.send_cmd(1'b0, 1'b1, 8'h20);
      cnt_valid(n);
      check("rd_b2b", n, 4);
      n = 0;
      ctl.send_cmd(1'b0, 1'b0, 8'h40);
      fork
         ctl.send_beats(w);
         cnt_valid(n);
      join
      check("rd_both", n, 4);
      rd_chk(8'h40);
      $display("t_b2b done");
   endtask
   // Side inputs and impedance control
   task automatic t_side;
      for (int v = 0; v < 2; v++) begin
         pll_off_n = v[0];
         term_range_sel = v[0];
         repeat (5) @(negedge clk);
         check("pll_en", pll_enable, v[0]);
         check("term_low", term_low_range, !v[0]);
      end
      repeat (2048) @(negedge clk);
      zq_walk(1'b1, 400, 6, 7);
      zq_walk(1'b0, 200, 3, 4);
      imp_ref_tied = 1'b1;
      repeat (70) @(negedge clk);
      check("zq_min", drive_code, DBS_ZQ_MINIMP);
      imp_ref_tied = 1'b0;
      $display("t_side done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      pll_off_n = 1'b1;
      term_range_sel = 1'b1;
      imp_ref_tied = 1'b0;
      imp_cmp_high = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check("code_rst", drive_code, DBS_ZQ_RST);
      check("echo_idle", echo_clk_out_n, 1);
      repeat (400) @(negedge clk);
      check("pll_on", pll_enable, 1);
      t_basic();
      t_b2b();
      t_side();
      stop_test();
   end
   // Watchdog
   initial begin
      #(50 * 20000);
      n_errors++;
      $display("BAD watchdog expected done seen timeout");
      stop_test();
   end
endmodule
